//--- rtl/sbd_addr_decoder.sv
// Per-master address decoder: fixed map, chip select and bridge selects
`timescale 1ns/1ps
`include "sbd_cfg.svh"
module sbd_addr_decoder
  import sbd_pkg::*;
#(
  parameter logic [7:0] VIS_MASK = `SBD_VIS_ALL
) (
  input  wire logic [31:0] addr,
  output logic             hit,
  output sbd_slave_t       slave,
  output logic [2:0]       cs,
  output logic [3:0]       step,
  output logic [1:0]       sub
);
  ////////////////////////////////////////////////////////////////////////
  // Region hits; full compare against base under a size mask, no remap input
  wire logic       h_ext  = (addr & `SBD_MASK_256M) == `SBD_EXT_LO_BASE;
  wire logic       h_cs1  = (addr & `SBD_MASK_256M) == `SBD_CS1_BASE;
  wire logic       h_cs5  = (addr & `SBD_MASK_64M) == `SBD_CS5_BASE;
  wire logic       h_sr0  = (addr & `SBD_MASK_16K) == `SBD_SRAM0_BASE;
  wire logic       h_sr1  = (addr & `SBD_MASK_16K) == `SBD_SRAM1_BASE;
  wire logic       h_dma  = (addr & `SBD_MASK_1K) == `SBD_DMA_BASE;
  wire logic       h_usb  = (addr & `SBD_MASK_1M) == `SBD_USB_BASE;
  wire logic [3:0] st     = addr[13:10];
  // Bridge windows only cover the listed 0x400 steps; the rest is a hole
  wire logic       h_pba  = (addr & `SBD_PB_WIN_MASK) == `SBD_PBA_BASE;
  wire logic       h_pbbw = (addr & `SBD_PB_WIN_MASK) == `SBD_PBB_BASE;
  wire logic       h_pbb  = h_pbbw && st != `SBD_PBB_GAP0 && st != `SBD_PBB_GAP1;
  wire logic [9:0] ofs    = addr[9:0];

  ////////////////////////////////////////////////////////////////////////
  // Slave choice; one fixed map at all times, boot included
  wire sbd_slave_t raw =
    (h_ext || h_cs1 || h_cs5) ? SL_EXT :
    h_sr0 ? SL_SRAM0 :
    h_sr1 ? SL_SRAM1 :
    h_dma ? SL_DMA :
    h_usb ? SL_USB :
    h_pba ? SL_PBA :
    h_pbb ? SL_PBB : SL_NONE;
  // A master may be denied some slaves, giving it its own map
  assign hit   = (raw != SL_NONE) && VIS_MASK[raw];
  assign slave = hit ? raw : SL_NONE;

  ////////////////////////////////////////////////////////////////////////
  // External chip select: the four low 64 Mbyte slots are 0, 4, 2, 3
  assign cs = h_cs1 ? `SBD_CS1 :
              h_cs5 ? `SBD_CS5 :
              addr[27:26] == 2'h0 ? `SBD_CS_SLOT0 :
              addr[27:26] == 2'h1 ? `SBD_CS_SLOT1 :
              addr[27:26] == 2'h2 ? `SBD_CS_SLOT2 : `SBD_CS_SLOT3;
  // Peripheral step behind a bridge, and the small blocks of step zero
  assign step = st;
  assign sub  = ofs < `SBD_RTC_OFS ? `SBD_SUB_PWR :
                ofs < `SBD_WDOG_OFS ? `SBD_SUB_RTC :
                ofs < `SBD_XIRQ_OFS ? `SBD_SUB_WDOG : `SBD_SUB_XIRQ;
endmodule

//--- rtl/sbd_cfg.svh
// Address map, bit positions and master numbering for the system bus decoder
`ifndef SBD_CFG_SVH
`define SBD_CFG_SVH
`define SBD_NUM_MST 7
`define SBD_MASK_256M 32'hF000_0000
`define SBD_MASK_64M 32'hFC00_0000
`define SBD_MASK_1M 32'hFFF0_0000
`define SBD_MASK_16K 32'hFFFF_C000
`define SBD_MASK_1K 32'hFFFF_FC00
`define SBD_EXT_LO_BASE 32'h0000_0000
`define SBD_CS1_BASE 32'h1000_0000
`define SBD_CS5_BASE 32'h2000_0000
`define SBD_SRAM0_BASE 32'h2400_0000
`define SBD_SRAM1_BASE 32'h2400_4000
`define SBD_DMA_BASE 32'hFF20_0000
`define SBD_USB_BASE 32'hFF30_0000
`define SBD_PBA_BASE 32'hFFE0_0000
`define SBD_PBB_BASE 32'hFFF0_0000
`define SBD_PB_WIN_MASK 32'hFFFF_C000
`define SBD_CS_SLOT0 3'h0
`define SBD_CS_SLOT1 3'h4
`define SBD_CS_SLOT2 3'h2
`define SBD_CS_SLOT3 3'h3
`define SBD_CS1 3'h1
`define SBD_CS5 3'h5
`define SBD_PBB_GAP0 4'h6
`define SBD_PBB_GAP1 4'h7
`define SBD_RTC_OFS 10'h080
`define SBD_WDOG_OFS 10'h0B0
`define SBD_XIRQ_OFS 10'h100
`define SBD_SUB_PWR 2'h0
`define SBD_SUB_RTC 2'h1
`define SBD_SUB_WDOG 2'h2
`define SBD_SUB_XIRQ 2'h3
`define SBD_VIS_ALL 8'hBF
`define SBD_ZERO_WAIT 8'h03
`define SBD_MST_IDS {4'h9, 4'h8, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0}
`define SBD_KBD_ADDR 32'hFFE0_3C00
`define SBD_WDOG_ADDR 32'hFFF0_00B0
`define SBD_MTX_ADDR 32'hFFF0_0800
`define SBD_GAP_ADDR 32'hFFF0_1800
`define SBD_STEP_KBD 4'hF
`define SBD_STEP_MTX 4'h2
`endif

//--- rtl/sbd_matrix.sv
// System bus matrix core: per-master decode, per-slave arbitration, routing
`timescale 1ns/1ps
`include "sbd_cfg.svh"
module sbd_matrix
  import sbd_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  input  wire logic [`SBD_NUM_MST-1:0]       m_req,
  input  wire logic [`SBD_NUM_MST-1:0]       m_write,
  input  wire logic [`SBD_NUM_MST-1:0][31:0] m_addr,
  output logic [`SBD_NUM_MST-1:0]            m_done,
  output logic [`SBD_NUM_MST-1:0]            m_err,
  output logic [7:0]                         s_sel,
  output logic [7:0]                         s_write,
  output logic [7:0][31:0]                   s_addr,
  output logic [7:0][3:0]                    s_master,
  input  wire logic [7:0]                    s_ready,
  output logic [2:0]                         ext_cs,
  output logic [3:0]                         pba_step,
  output logic [3:0]                         pbb_step,
  output logic [1:0]                         pbb_sub
);
  localparam int NM = `SBD_NUM_MST;
  // Port index to bus master number
  localparam logic [NM-1:0][3:0] MST_ID = `SBD_MST_IDS;

  ////////////////////////////////////////////////////////////////////////
  // Per-master state
  sbd_mst_state_t [NM-1:0] mst_state;
  sbd_mst_state_t [NM-1:0] next_state;
  sbd_slave_t     [NM-1:0] tgt;
  sbd_slave_t     [NM-1:0] next_tgt;
  logic [NM-1:0][31:0]     addr_l;
  logic [NM-1:0][31:0]     next_addr;
  logic [NM-1:0]           wr_l;
  logic [NM-1:0]           next_wr;
  logic [NM-1:0][2:0]      cs_l;
  logic [NM-1:0][2:0]      next_cs;
  logic [NM-1:0][3:0]      step_l;
  logic [NM-1:0][3:0]      next_step;
  logic [NM-1:0][1:0]      sub_l;
  logic [NM-1:0][1:0]      next_sub;
  logic [NM-1:0]           next_done;
  logic [NM-1:0]           next_err;

  // Decoder outputs
  logic [NM-1:0]           dec_hit;
  sbd_slave_t [NM-1:0]     dec_slave;
  logic [NM-1:0][2:0]      dec_cs;
  logic [NM-1:0][3:0]      dec_step;
  logic [NM-1:0][1:0]      dec_sub;

  // Slave side
  wire logic [7:0]         gnt_valid;
  wire logic [7:0][2:0]    gnt_idx;
  logic [7:0][NM-1:0]      arb_req;
  logic [7:0]              slv_done;
  logic [7:0]              next_sel;
  logic [7:0]              next_swr;
  logic [7:0][31:0]        next_saddr;
  logic [7:0][3:0]         next_smst;
  logic [2:0]              next_ext_cs;
  logic [3:0]              next_pba_step;
  logic [3:0]              next_pbb_step;
  logic [1:0]              next_pbb_sub;

  ////////////////////////////////////////////////////////////////////////
  // One decoder per master on its own path
  for (genvar i = 0; i < NM; i++) begin : g_dec
    sbd_addr_decoder #(
      .VIS_MASK (`SBD_VIS_ALL)
    ) u_dec (
      .addr  (m_addr[i]),
      .hit   (dec_hit[i]),
      .slave (dec_slave[i]),
      .cs    (dec_cs[i]),
      .step  (dec_step[i]),
      .sub   (dec_sub[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // One arbiter per slave number; DMA config and USB data get their own
  // slots straight on the matrix. Number 6 is unused and never granted.
  for (genvar k = 0; k < 8; k++) begin : g_arb
    if (k == int'(SL_NONE)) begin : g_gap
      assign gnt_valid[k] = 1'b0;
      assign gnt_idx[k]   = 3'h0;
    end else begin : g_slv
      sbd_slave_arbiter #(
        .ROUND_ROBIN (1'b1)
      ) u_arb (
        .mclk      (mclk),
        .rstn      (rstn),
        .req       (arb_req[k]),
        .done      (slv_done[k]),
        .gnt_valid (gnt_valid[k]),
        .gnt_idx   (gnt_idx[k])
      );
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Waiting masters request the arbiter named by their slave number
  always_comb begin
    arb_req = '0;
    for (int i = 0; i < NM; i++) begin
      if (mst_state[i] == MS_BUSY) begin
        arb_req[tgt[i]][i] = 1'b1;
      end
    end
  end

  // SRAM slaves finish in their first selected cycle; others wait on ready
  assign slv_done = s_sel & (s_ready | `SBD_ZERO_WAIT);

  ////////////////////////////////////////////////////////////////////////
  // Master side: a request is taken only while idle, miss answers at once
  always_comb begin
    next_state = mst_state;
    next_tgt   = tgt;
    next_addr  = addr_l;
    next_wr    = wr_l;
    next_cs    = cs_l;
    next_step  = step_l;
    next_sub   = sub_l;
    next_done  = '0;
    next_err   = '0;
    for (int i = 0; i < NM; i++) begin
      if (mst_state[i] == MS_IDLE && m_req[i]) begin
        next_addr[i] = m_addr[i];
        next_wr[i]   = m_write[i];
        next_cs[i]   = dec_cs[i];
        next_step[i] = dec_step[i];
        next_sub[i]  = dec_sub[i];
        if (dec_hit[i]) begin
          next_state[i] = MS_BUSY;
          next_tgt[i]   = dec_slave[i];
        end else begin
          next_done[i] = 1'b1;
          next_err[i]  = 1'b1;
        end
      end
    end
    for (int k = 0; k < 8; k++) begin
      if (slv_done[k]) begin
        next_state[gnt_idx[k]] = MS_IDLE;
        next_tgt[gnt_idx[k]]   = SL_NONE;
        next_done[gnt_idx[k]]  = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave side: select follows the grant one cycle later and drops as the
  // access completes, so a slave never sees two masters at once
  always_comb begin
    next_saddr    = s_addr;
    next_swr      = s_write;
    next_smst     = s_master;
    next_ext_cs   = ext_cs;
    next_pba_step = pba_step;
    next_pbb_step = pbb_step;
    next_pbb_sub  = pbb_sub;
    next_sel      = gnt_valid & ~slv_done;
    for (int k = 0; k < 8; k++) begin
      if (gnt_valid[k]) begin
        next_saddr[k] = addr_l[gnt_idx[k]];
        next_swr[k]   = wr_l[gnt_idx[k]];
        next_smst[k]  = MST_ID[gnt_idx[k]];
      end
    end
    if (gnt_valid[SL_EXT]) begin
      next_ext_cs = cs_l[gnt_idx[SL_EXT]];
    end
    if (gnt_valid[SL_PBA]) begin
      next_pba_step = step_l[gnt_idx[SL_PBA]];
    end
    if (gnt_valid[SL_PBB]) begin
      next_pbb_step = step_l[gnt_idx[SL_PBB]];
      next_pbb_sub  = sub_l[gnt_idx[SL_PBB]];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State and output registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mst_state <= '{default: MS_IDLE};
      tgt       <= '{default: SL_NONE};
      addr_l    <= '0;
      wr_l      <= '0;
      cs_l      <= '0;
      step_l    <= '0;
      sub_l     <= '0;
      m_done    <= '0;
      m_err     <= '0;
    end else begin
      mst_state <= next_state;
      tgt       <= next_tgt;
      addr_l    <= next_addr;
      wr_l      <= next_wr;
      cs_l      <= next_cs;
      step_l    <= next_step;
      sub_l     <= next_sub;
      m_done    <= next_done;
      m_err     <= next_err;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_sel    <= 8'h00;
      s_write  <= 8'h00;
      s_addr   <= '0;
      s_master <= '0;
      ext_cs   <= 3'h0;
      pba_step <= 4'h0;
      pbb_step <= 4'h0;
      pbb_sub  <= 2'h0;
    end else begin
      s_sel    <= next_sel;
      s_write  <= next_swr;
      s_addr   <= next_saddr;
      s_master <= next_smst;
      ext_cs   <= next_ext_cs;
      pba_step <= next_pba_step;
      pbb_step <= next_pbb_step;
      pbb_sub  <= next_pbb_sub;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks, mostly on master port 0
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_take0;
    mst_state[0] == MS_IDLE && m_req[0];
  endsequence
  sequence s_sram_done0;
    ##[4:30] (m_done[0] && !m_err[0]);
  endsequence

  for (genvar i = 0; i < NM; i++) begin : g_chk
    a_miss_error: assert property (
      mst_state[i] == MS_IDLE && m_req[i] && !dec_hit[i]
      |=> m_done[i] && m_err[i] && mst_state[i] == MS_IDLE && arb_req[SL_NONE] == '0)
      else $error("unmapped access not answered with error");
  end

  a_sram_served: assert property ((s_take0 and (dec_slave[0] == SL_SRAM0)) |-> s_sram_done0)
    else $error("sram access not served in time");
  a_sram_one_cycle: assert property (s_sel[1] |=> !s_sel[1] && m_done[$past(gnt_idx[1])])
    else $error("sram select held over one cycle");
  a_cs1_region: assert property ((s_take0 and ((m_addr[0] & `SBD_MASK_256M) == `SBD_CS1_BASE))
    |=> tgt[0] == SL_EXT && cs_l[0] == `SBD_CS1)
    else $error("cs1 region decoded wrongly");
  a_sram1_region: assert property ((s_take0 and (m_addr[0] == `SBD_SRAM1_BASE))
    |=> tgt[0] == SL_SRAM1)
    else $error("second sram decoded wrongly");
  a_usb_region: assert property ((s_take0 and (m_addr[0] == `SBD_USB_BASE))
    |=> tgt[0] == SL_USB)
    else $error("usb data port decoded wrongly");
  a_pba_step: assert property ((s_take0 and (m_addr[0] == `SBD_KBD_ADDR))
    |=> tgt[0] == SL_PBA && step_l[0] == `SBD_STEP_KBD)
    else $error("keyboard port step wrong");
  a_wdt_sub: assert property ((s_take0 and (m_addr[0] == `SBD_WDOG_ADDR))
    |=> tgt[0] == SL_PBB && sub_l[0] == `SBD_SUB_WDOG)
    else $error("watchdog select wrong");
  a_mtx_step: assert property ((s_take0 and (m_addr[0] == `SBD_MTX_ADDR))
    |=> tgt[0] == SL_PBB && step_l[0] == `SBD_STEP_MTX)
    else $error("matrix config step wrong");
  a_bridge_hole: assert property ((s_take0 and (m_addr[0] == `SBD_GAP_ADDR))
    |=> m_done[0] && m_err[0])
    else $error("bridge hole not answered with error");
  a_master_id: assert property (s_sel[SL_EXT]
    |-> s_master[SL_EXT] == MST_ID[gnt_idx[SL_EXT]] && gnt_valid[SL_EXT])
    else $error("master number on slave side wrong");
endmodule

//--- rtl/sbd_pkg.sv
// Types shared by the system bus decoder files
package sbd_pkg;
  typedef enum logic [2:0] {
    SL_SRAM0 = 3'h0,
    SL_SRAM1 = 3'h1,
    SL_PBA   = 3'h2,
    SL_PBB   = 3'h3,
    SL_EXT   = 3'h4,
    SL_USB   = 3'h5,
    SL_NONE  = 3'h6,
    SL_DMA   = 3'h7
  } sbd_slave_t;
  typedef enum logic {
    MS_IDLE = 1'b0,
    MS_BUSY = 1'b1
  } sbd_mst_state_t;
endpackage

//--- rtl/sbd_slave_arbiter.sv
// Per-slave arbiter: round robin or fixed priority, grant held to completion
`timescale 1ns/1ps
`include "sbd_cfg.svh"
module sbd_slave_arbiter
  import sbd_pkg::*;
#(
  parameter bit ROUND_ROBIN = 1'b1
) (
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  input  wire logic [`SBD_NUM_MST-1:0] req,
  input  wire logic                    done,
  output logic                         gnt_valid,
  output logic [2:0]                   gnt_idx
);
  logic [2:0] last;
  logic [2:0] pick;
  logic       any;

  ////////////////////////////////////////////////////////////////////////
  // Search starts after the last winner so no master starves
  always_comb begin
    int base;
    int c;
    base = ROUND_ROBIN ? int'(last) + 1 : 0;
    c    = 0;
    pick = 3'h0;
    any  = 1'b0;
    for (int j = `SBD_NUM_MST - 1; j >= 0; j--) begin
      c = (base + j) % `SBD_NUM_MST;
      if (req[c]) begin
        pick = 3'(c);
        any  = 1'b1;
      end
    end
  end

  // Grant is kept until the slave completes, then released for one cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gnt_valid <= 1'b0;
      gnt_idx   <= 3'h0;
      last      <= 3'h0;
    end else if (!gnt_valid && any) begin
      gnt_valid <= 1'b1;
      gnt_idx   <= pick;
      last      <= pick;
    end else if (gnt_valid && done) begin
      gnt_valid <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_grant_held: assert property (gnt_valid && !done |=> gnt_valid && $stable(gnt_idx))
    else $error("grant moved before completion");
  a_grant_pick: assert property (!gnt_valid && any |=> gnt_valid && gnt_idx == $past(pick))
    else $error("pending request not granted");
endmodule

//--- sim/sbd_matrix_tb.sv
// Self-checking bench for the system bus matrix decode and routing
`timescale 1ns/1ps
`include "sbd_cfg.svh"
module sbd_matrix_tb
  import sbd_pkg::*;
;
  logic                          mclk;
  logic                          rstn;
  logic [`SBD_NUM_MST-1:0]       m_req;
  logic [`SBD_NUM_MST-1:0]       m_write;
  logic [`SBD_NUM_MST-1:0][31:0] m_addr;
  logic [`SBD_NUM_MST-1:0]       m_done;
  logic [`SBD_NUM_MST-1:0]       m_err;
  logic [7:0]                    s_sel;
  logic [7:0]                    s_write;
  logic [7:0][31:0]              s_addr;
  logic [7:0][3:0]               s_master;
  logic [7:0]                    s_ready;
  logic [2:0]                    ext_cs;
  logic [3:0]                    pba_step;
  logic [3:0]                    pbb_step;
  logic [1:0]                    pbb_sub;
  logic [3:0]                    wait_cycles;
  logic [7:0]                    cap_sel;
  logic [3:0]                    cap_master;
  logic [2:0]                    cap_cs;
  logic [3:0]                    cap_pba;
  logic [3:0]                    cap_pbb;
  logic [1:0]                    cap_sub;
  logic                          cap_write;
  logic [31:0]                   cap_addr;
  int                            lat;
  int                            mismatches;
  int                            checked;
  int                            cycles;

  sbd_matrix sbd_matrix_inst (.mclk(mclk), .rstn(rstn), .m_req(m_req), .m_write(m_write), .m_addr(m_addr),
    .m_done(m_done), .m_err(m_err), .s_sel(s_sel), .s_write(s_write), .s_addr(s_addr), .s_master(s_master),
    .s_ready(s_ready), .ext_cs(ext_cs), .pba_step(pba_step), .pbb_step(pbb_step), .pbb_sub(pbb_sub));
  sbd_slave_model sbd_slave_model_inst (.mclk(mclk), .rstn(rstn), .s_sel(s_sel), .wait_cycles(wait_cycles),
    .s_ready(s_ready));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the 75 transfers need far fewer cycles
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One pulse request, then sample every cycle until done; what any slave saw is captured
  task automatic xfer(input int p, input logic [31:0] a, input logic wr);
    @(posedge mclk);
    m_req[p]   <= 1'b1;
    m_addr[p]  <= a;
    m_write[p] <= wr;
    @(posedge mclk);
    m_req[p] <= 1'b0;
    cap_sel = '0;
    lat = 0;
    do begin
      #1;
      lat++;
      cap_sel |= s_sel;
      for (int k = 0; k < 8; k++) begin
        if (s_sel[k]) begin
          cap_master = s_master[k];
          cap_write  = s_write[k];
          cap_addr   = s_addr[k];
        end
      end
      if (s_sel[4]) cap_cs = ext_cs;
      if (s_sel[2]) cap_pba = pba_step;
      if (s_sel[3]) begin
        cap_pbb = pbb_step;
        cap_sub = pbb_sub;
      end
      if (m_done[p] !== 1'b1) @(posedge mclk);
    end while (m_done[p] !== 1'b1 && lat < 40);
  endtask
  // Transfer plus routing judgement; elat 0 leaves the latency unchecked
  task automatic go(input int p, input logic [31:0] a, input logic wr, input sbd_slave_t es, input int elat);
    xfer(p, a, wr);
    chk(m_done[p], 1'b1);
    chk(m_err[p], es == SL_NONE);
    chk(cap_sel, (es == SL_NONE) ? 8'h00 : (8'h01 << es));
    if (elat != 0) chk(lat, elat);
    if (es != SL_NONE) begin
      chk(cap_addr, a);
      chk(cap_write, wr);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_ext();
    logic [31:0] a [9] = '{32'h0000_0000, 32'h03FF_FFFC, 32'h0400_0000, 32'h0800_0000, 32'h0C00_0000,
                           32'h1000_0000, 32'h1FFF_FFFC, 32'h2000_0000, 32'h23FF_FFFC};
    logic [2:0]  c [9] = '{3'h0, 3'h0, 3'h4, 3'h2, 3'h3, 3'h1, 3'h1, 3'h5, 3'h5};
    for (int i = 0; i < 9; i++) begin
      go(0, a[i], i[0], SL_EXT, 0);
      chk(cap_cs, c[i]);
    end
  endtask
  task automatic t_sram();
    go(1, 32'h2400_0000, 1'b1, SL_SRAM0, 4);
    go(1, 32'h2400_3FFC, 1'b0, SL_SRAM0, 4);
    go(1, 32'h2400_4000, 1'b0, SL_SRAM1, 4);
    go(1, 32'h2400_7FFC, 1'b1, SL_SRAM1, 4);
    go(1, 32'h2400_8000, 1'b0, SL_NONE, 1);
  endtask
  task automatic t_high();
    @(posedge mclk);
    wait_cycles <= 4'h3;
    go(2, 32'hFF20_0000, 1'b1, SL_DMA, 7);
    go(2, 32'hFF20_03FC, 1'b0, SL_DMA, 7);
    go(2, 32'hFF20_0400, 1'b0, SL_NONE, 1);
    go(0, 32'hFF30_0000, 1'b0, SL_USB, 7);
    go(2, 32'hFF3F_FFFC, 1'b1, SL_USB, 7);
    go(2, 32'hFF40_0000, 1'b0, SL_NONE, 1);
    @(posedge mclk);
    wait_cycles <= 4'h0;
  endtask
  task automatic t_miss();
    logic [31:0] a [4] = '{32'h3000_0000, 32'h8000_0000, 32'hFF00_0000, 32'hFFD0_0000};
    for (int i = 0; i < 4; i++) begin
      go(3, a[i], i[0], SL_NONE, 1);
    end
    @(posedge mclk);
    #1;
    chk(m_done[3], 1'b0);
  endtask
  task automatic t_masters();
    logic [3:0] ids [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9};
    for (int i = 0; i < 7; i++) begin
      go(i, 32'h2400_4000 + i * 4, 1'b1, SL_SRAM1, 4);
      chk(cap_master, ids[i]);
    end
  endtask
  task automatic t_pba();
    for (int s = 0; s < 16; s++) begin
      go(0, 32'hFFE0_0000 + s * 32'h400, 1'b0, SL_PBA, 0);
      chk(cap_pba, s[3:0]);
    end
    go(4, 32'hFFE0_4000, 1'b0, SL_NONE, 1);
  endtask
  task automatic t_pbb();
    logic [31:0] a [8] = '{32'hFFF0_0000, 32'hFFF0_007C, 32'hFFF0_0080, 32'hFFF0_00AC, 32'hFFF0_00B0,
                           32'hFFF0_00FC, 32'hFFF0_0100, 32'hFFF0_03FC};
    for (int i = 0; i < 8; i++) begin
      go(0, a[i], 1'b0, SL_PBB, 0);
      chk(cap_sub, i / 2);
    end
    for (int s = 1; s < 16; s++) begin
      go(0, 32'hFFF0_0000 + s * 32'h400, 1'b1, (s == 6 || s == 7) ? SL_NONE : SL_PBB, 0);
      if (s != 6 && s != 7) chk(cap_pbb, s[3:0]);
    end
    go(6, 32'hFFF0_4000, 1'b0, SL_NONE, 1);
  endtask
  // Two masters fight for one SRAM while a third uses the other SRAM untouched
  task automatic t_contend();
    int d [3];
    d = '{0, 0, 0};
    @(posedge mclk);
    m_req[2:0] <= 3'b111;
    m_addr[0]  <= 32'h2400_0000;
    m_addr[1]  <= 32'h2400_0010;
    m_addr[2]  <= 32'h2400_4000;
    @(posedge mclk);
    m_req[2:0] <= 3'b000;
    for (int n = 1; n < 20; n++) begin
      #1;
      for (int i = 0; i < 3; i++) begin
        if (m_done[i] === 1'b1) d[i] = n;
      end
      @(posedge mclk);
    end
    chk(d[2], 4);
    chk((d[0] == 4) ^ (d[1] == 4), 1'b1);
    chk(d[0] > 4 || d[1] > 4, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn        = 1'b0;
    m_req       = '0;
    m_write     = '0;
    m_addr      = '0;
    wait_cycles = 4'h0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    t_ext();
    t_sram();
    t_high();
    t_miss();
    t_masters();
    t_pba();
    t_pbb();
    t_contend();
    final_report();
  end
endmodule

//--- sim/sbd_slave_model.sv
// Behavioural slave side of the matrix: answers every selected slave after a set wait
`timescale 1ns/1ps
module sbd_slave_model (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [7:0] s_sel,
  input  wire logic [3:0] wait_cycles,
  output logic [7:0]      s_ready
);
  logic [7:0][3:0] cnt;
  logic            flip;
  // Cycles spent selected per slave, restarted whenever the select drops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt  <= '0;
      flip <= 1'b0;
    end else begin
      flip <= ~flip;
      for (int k = 0; k < 8; k++) begin
        cnt[k] <= s_sel[k] ? cnt[k] + 4'h1 : 4'h0;
      end
    end
  end
  // Unselected ready lines toggle, so a stray ready cannot hide behind a quiet low
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      s_ready[k] = s_sel[k] ? (cnt[k] >= wait_cycles) : flip;
    end
  end
endmodule
